// *** common/rsl_pkg.sv ***
// rsl_pkg: widths, defaults, log layout and compare codes for the shutdown rule logic.
// assumes: imported whole by every design file of the block.
package rsl_pkg;

  // data widths
  localparam int unsigned RSL_VAL_W   = 32;
  localparam int unsigned RSL_ID_W    = 8;
  localparam int unsigned RSL_CHAN_W  = 4;
  localparam int unsigned RSL_TRIP_W  = 4;
  localparam int unsigned RSL_PULSE_W = 16;
  localparam int unsigned RSL_REG_W   = 16;

  // defaults: own address and consecutive trip count
  localparam logic [7:0] RSL_OWN_ADDR_DEF = 8'hF7;
  localparam logic [3:0] RSL_TRIP_DEF     = 4'h1;

  // local digital outputs occupy the first slots, channels 1 and 2
  localparam int unsigned RSL_NUM_LOCAL    = 2;
  localparam logic [3:0]  RSL_LOCAL_CHAN0  = 4'h1;

  // readable event log: holding registers 7000..7024
  localparam logic [15:0] RSL_LOG_BASE     = 16'h1B58;
  localparam int unsigned RSL_LOG_DEPTH    = 5;
  localparam int unsigned RSL_LOG_WORDS    = 5;
  localparam logic [15:0] RSL_LOG_RST      = 16'h0000;

  // word positions inside one log entry
  localparam int unsigned RSL_EW_SEQ       = 0;
  localparam int unsigned RSL_EW_RULE      = 1;
  localparam int unsigned RSL_EW_SRC       = 2;
  localparam int unsigned RSL_EW_VAL_HI    = 3;
  localparam int unsigned RSL_EW_VAL_LO    = 4;
  localparam int unsigned RSL_EV_STATE_BIT = 15;

  typedef enum logic [1:0] {
    RSL_CMP_GT,
    RSL_CMP_LT,
    RSL_CMP_EQ
  } rsl_cmp_t;

endpackage

// *** design/rsl_rule_eval.sv ***
// rsl_rule_eval: one rule of the table; hysteresis and consecutive-trip counting.
// assumes: one check-in per cycle at most, synchronous active-low reset.
`timescale 1ns/1ps
module rsl_rule_eval
  import rsl_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // rule configuration
  input  wire logic                  cfg_en,
  input  wire logic [RSL_ID_W-1:0]   cfg_src_id,
  input  wire logic [1:0]            cfg_cmp_op,
  input  wire logic [RSL_VAL_W-1:0]  cfg_run_thr,
  input  wire logic [RSL_VAL_W-1:0]  cfg_stop_thr,
  input  wire logic [RSL_TRIP_W-1:0] consecutive_trip_count,
  // check-in stream
  input  wire logic                  checkin_valid,
  input  wire logic [RSL_ID_W-1:0]   checkin_id,
  input  wire logic [RSL_VAL_W-1:0]  checkin_value,
  // rule state
  output logic                       run_req_q,
  output logic                       change_q
);

  logic [RSL_TRIP_W-1:0] trip_cnt_q;
  logic [RSL_TRIP_W-1:0] trip_cnt_d;
  logic [RSL_TRIP_W-1:0] trip_need;
  logic                  hit;
  logic                  run_ok;
  logic                  stop_ok;

  function automatic logic meets(input logic [1:0] op, input logic [RSL_VAL_W-1:0] v,
                                 input logic [RSL_VAL_W-1:0] thr, input logic is_run);
    case (rsl_cmp_t'(op))
      RSL_CMP_GT: meets = is_run ? (v > thr) : (v < thr);
      RSL_CMP_LT: meets = is_run ? (v < thr) : (v > thr);
      RSL_CMP_EQ: meets = (v == thr);
      default:    meets = 1'b0;
    endcase
  endfunction

  assign hit        = cfg_en && checkin_valid && (checkin_id == cfg_src_id);
  assign run_ok     = meets(cfg_cmp_op, checkin_value, cfg_run_thr, 1'b1);
  assign stop_ok    = meets(cfg_cmp_op, checkin_value, cfg_stop_thr, 1'b0);
  // a zero count would also trip on the first stop check-in; treat it as one
  assign trip_need  = (consecutive_trip_count == '0) ? RSL_TRIP_DEF : consecutive_trip_count;
  assign trip_cnt_d = (trip_cnt_q >= trip_need) ? trip_need : RSL_TRIP_W'(trip_cnt_q + 1'b1);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      run_req_q  <= 1'b0;
      trip_cnt_q <= '0;
      change_q   <= 1'b0;
    end else begin
      change_q <= 1'b0;
      if (!cfg_en) begin
        run_req_q  <= 1'b0;
        trip_cnt_q <= '0;
      end else if (hit) begin
        if (run_ok) begin
          trip_cnt_q <= '0;
          change_q   <= !run_req_q;
          run_req_q  <= 1'b1;
        end else if (stop_ok) begin
          trip_cnt_q <= trip_cnt_d;
          if (trip_cnt_d >= trip_need) begin
            change_q  <= run_req_q;
            run_req_q <= 1'b0;
          end
        end else begin
          trip_cnt_q <= '0;
        end
      end
    end
  end

endmodule // rsl_rule_eval

// *** design/rsl_remote_shutdown_logic.sv ***
// rsl_remote_shutdown_logic: rule table, per-destination AND, failsafe, latch, pulse, event log.
// assumes: configuration ports held steady by firmware, node presence supplied from outside,
// check-ins arrive as single-cycle strobes synchronous to clock.
//
// Overview of operation
// - energize above run, de-energize below shutdown
// - destination energized only if all rules agree
// - five latest events readable at 7000-7024
// - any reset clears the readable log
// - failsafe: missing source forces de-energize
// - no failsafe: ignore missing sources
// - latch: rules only de-energize, writes restore
// - local outputs: rules, master writes, manual
// - shutdown needs consecutive trips; run immediate
// - own address selects local digital outputs
// - pulse mode emits timed pulse instead
`timescale 1ns/1ps
module rsl_remote_shutdown_logic
  import rsl_pkg::*;
#(
  parameter int unsigned         NR       = 8,
  parameter int unsigned         NS       = 6,
  parameter logic [RSL_ID_W-1:0] OWN_ADDR = RSL_OWN_ADDR_DEF,
  localparam int unsigned        SLOT_W   = $clog2(NS)
) (
  // clock and reset
  input  wire logic                             clock,
  input  wire logic                             resetn,
  // rule table
  input  wire logic [NR-1:0]                    cfg_rule_en,
  input  wire logic [NR-1:0][RSL_ID_W-1:0]      cfg_src_id,
  input  wire logic [NR-1:0][1:0]               cfg_cmp_op,
  input  wire logic [NR-1:0][RSL_VAL_W-1:0]     cfg_run_thr,
  input  wire logic [NR-1:0][RSL_VAL_W-1:0]     cfg_stop_thr,
  input  wire logic [NR-1:0][RSL_TRIP_W-1:0]    consecutive_trip_count,
  input  wire logic [NR-1:0][RSL_ID_W-1:0]      cfg_dest_id,
  input  wire logic [NR-1:0][RSL_CHAN_W-1:0]    cfg_dest_chan,
  input  wire logic [NR-1:0]                    src_present,
  // destination slots
  input  wire logic [NS-1:0][RSL_ID_W-1:0]      slot_id,
  input  wire logic [NS-1:0][RSL_CHAN_W-1:0]    slot_chan,
  input  wire logic [NS-1:0]                    failsafe_en,
  input  wire logic [NS-1:0]                    hold_off_until_master_write,
  input  wire logic [NS-1:0]                    pulse_en,
  input  wire logic [NS-1:0]                    pulse_on_run,
  input  wire logic [NS-1:0][RSL_PULSE_W-1:0]   pulse_cycles,
  // check-in stream
  input  wire logic                             checkin_valid,
  input  wire logic [RSL_ID_W-1:0]              checkin_id,
  input  wire logic [RSL_VAL_W-1:0]             checkin_value,
  // master coil write and manual command
  input  wire logic                             coil_wr_valid,
  input  wire logic [SLOT_W-1:0]                coil_wr_slot,
  input  wire logic                             coil_wr_value,
  input  wire logic                             manual_wr_valid,
  input  wire logic                             manual_wr_sel,
  input  wire logic                             manual_wr_value,
  // log read
  input  wire logic [RSL_REG_W-1:0]             log_rd_addr,
  output logic [RSL_REG_W-1:0]                  log_rd_data_q,
  // destination outputs
  output logic [NS-1:0]                         relay_cmd_q
);

  logic [NR-1:0]                    rule_req;
  logic [NR-1:0]                    rule_chg;
  logic [NS-1:0]                    logic_on;
  logic [NS-1:0]                    trigger;
  logic [NS-1:0]                    logic_prev_q;
  logic [NS-1:0]                    state_q;
  logic [NS-1:0]                    state_prev_q;
  logic [NS-1:0][RSL_PULSE_W-1:0]   pulse_cnt_q;
  logic [NS-1:0][RSL_PULSE_W-1:0]   pulse_cnt_d;
  logic [RSL_VAL_W-1:0]             last_value_q;
  logic [RSL_ID_W-1:0]              last_id_q;
  logic [RSL_REG_W-1:0]             log_seq_q;
  logic [RSL_REG_W-1:0]             log_mem [RSL_LOG_DEPTH][RSL_LOG_WORDS];
  logic                             ev_any;
  logic [7:0]                       ev_rule;

  for (genvar r = 0; r < NR; r++) begin : g_rule
    rsl_rule_eval u_rule (
      .clock                  (clock),
      .resetn                 (resetn),
      .cfg_en                 (cfg_rule_en[r]),
      .cfg_src_id             (cfg_src_id[r]),
      .cfg_cmp_op             (cfg_cmp_op[r]),
      .cfg_run_thr            (cfg_run_thr[r]),
      .cfg_stop_thr           (cfg_stop_thr[r]),
      .consecutive_trip_count (consecutive_trip_count[r]),
      .checkin_valid          (checkin_valid),
      .checkin_id             (checkin_id),
      .checkin_value          (checkin_value),
      .run_req_q              (rule_req[r]),
      .change_q               (rule_chg[r])
    );
  end

  // per-slot combination of every rule aimed at it
  always_comb begin
    logic [RSL_ID_W-1:0]   eff_id;
    logic [RSL_CHAN_W-1:0] eff_chan;
    logic                  contrib;
    logic                  any_active;
    logic                  all_on;
    logic                  fail;
    logic                  chg;
    eff_id     = '0;
    eff_chan   = '0;
    contrib    = 1'b0;
    any_active = 1'b0;
    all_on     = 1'b1;
    fail       = 1'b0;
    chg        = 1'b0;
    for (int s = 0; s < NS; s++) begin
      // local slots answer to own address
      if (s < RSL_NUM_LOCAL) begin
        eff_id   = OWN_ADDR;
        eff_chan = RSL_CHAN_W'(RSL_LOCAL_CHAN0 + RSL_CHAN_W'(s));
      end else begin
        eff_id   = slot_id[s];
        eff_chan = slot_chan[s];
      end
      any_active = 1'b0;
      all_on     = 1'b1;
      fail       = 1'b0;
      chg        = 1'b0;
      for (int r = 0; r < NR; r++) begin
        contrib = cfg_rule_en[r] && (cfg_dest_id[r] == eff_id) && (cfg_dest_chan[r] == eff_chan);
        if (contrib && !src_present[r] && failsafe_en[s]) begin
          fail = 1'b1;
        end
        if (contrib && src_present[r]) begin
          any_active = 1'b1;
          all_on = all_on && rule_req[r];
          chg    = chg || rule_chg[r];
        end
      end
      logic_on[s] = any_active && all_on && !fail;
      trigger[s]  = chg || (logic_on[s] != logic_prev_q[s]);
    end
  end

  // slot state: rule decisions, then external writes on top
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q      <= '0;
      logic_prev_q <= '0;
    end else begin
      logic_prev_q <= logic_on;
      for (int s = 0; s < NS; s++) begin
        if (trigger[s]) begin
          if (hold_off_until_master_write[s]) begin
            if (!logic_on[s]) begin
              state_q[s] <= 1'b0;
            end
          end else begin
            state_q[s] <= logic_on[s];
          end
        end
        if (coil_wr_valid && (coil_wr_slot == SLOT_W'(s))) begin
          state_q[s] <= coil_wr_value;
        end
        if (s < RSL_NUM_LOCAL && manual_wr_valid && (manual_wr_sel == s[0])) begin
          state_q[s] <= manual_wr_value;
        end
      end
    end
  end

  always_comb begin
    for (int s = 0; s < NS; s++) begin
      if (pulse_en[s] && (pulse_on_run[s] ? (state_q[s] && !state_prev_q[s])
                                          : (!state_q[s] && state_prev_q[s]))) begin
        pulse_cnt_d[s] = pulse_cycles[s];
      end else if (pulse_cnt_q[s] != '0) begin
        pulse_cnt_d[s] = RSL_PULSE_W'(pulse_cnt_q[s] - 1'b1);
      end else begin
        pulse_cnt_d[s] = '0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_prev_q <= '0;
      pulse_cnt_q  <= '0;
      relay_cmd_q  <= '0;
    end else begin
      state_prev_q <= state_q;
      pulse_cnt_q  <= pulse_cnt_d;
      for (int s = 0; s < NS; s++) begin
        relay_cmd_q[s] <= pulse_en[s] ? (pulse_cnt_d[s] != '0) : state_q[s];
      end
    end
  end

  // lowest-numbered changing rule is logged; simultaneous others are dropped
  always_comb begin
    ev_any  = 1'b0;
    ev_rule = 8'h00;
    for (int r = NR - 1; r >= 0; r--) begin
      if (rule_chg[r]) begin
        ev_any  = 1'b1;
        ev_rule = 8'(r);
      end
    end
  end

  // change pulse trails the check-in by one cycle, so keep that check-in
  always_ff @(posedge clock) begin
    if (!resetn) begin
      last_value_q <= '0;
      last_id_q    <= '0;
    end else if (checkin_valid) begin
      last_value_q <= checkin_value;
      last_id_q    <= checkin_id;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      log_seq_q <= RSL_LOG_RST;
      for (int e = 0; e < RSL_LOG_DEPTH; e++) begin
        for (int w = 0; w < RSL_LOG_WORDS; w++) begin
          log_mem[e][w] <= RSL_LOG_RST;
        end
      end
    end else if (ev_any) begin
      log_seq_q <= RSL_REG_W'(log_seq_q + 1'b1);
      for (int e = RSL_LOG_DEPTH - 1; e > 0; e--) begin
        for (int w = 0; w < RSL_LOG_WORDS; w++) begin
          log_mem[e][w] <= log_mem[e-1][w];
        end
      end
      log_mem[0][RSL_EW_SEQ]    <= RSL_REG_W'(log_seq_q + 1'b1);
      log_mem[0][RSL_EW_RULE]   <= {rule_req[ev_rule[$clog2(NR)-1:0]], 7'h00, ev_rule};
      log_mem[0][RSL_EW_SRC]    <= {8'h00, last_id_q};
      log_mem[0][RSL_EW_VAL_HI] <= last_value_q[31:16];
      log_mem[0][RSL_EW_VAL_LO] <= last_value_q[15:0];
    end
  end

  // registered read, zero outside the window
  always_ff @(posedge clock) begin
    if (!resetn) begin
      log_rd_data_q <= RSL_LOG_RST;
    end else begin
      log_rd_data_q <= RSL_LOG_RST;
      for (int e = 0; e < RSL_LOG_DEPTH; e++) begin
        for (int w = 0; w < RSL_LOG_WORDS; w++) begin
          if (log_rd_addr == RSL_REG_W'(RSL_LOG_BASE + RSL_REG_W'(e * RSL_LOG_WORDS + w))) begin
            log_rd_data_q <= log_mem[e][w];
          end
        end
      end
    end
  end

endmodule // rsl_remote_shutdown_logic

// *** tb/rsl_monitor.sv ***
// rsl_monitor: port checks for the shutdown rule logic.
// assumes: bound into rsl_remote_shutdown_logic, single clock domain.
`timescale 1ns/1ps
module rsl_monitor
  import rsl_pkg::*;
#(
  parameter int unsigned  NR     = 8,
  parameter int unsigned  NS     = 6,
  localparam int unsigned SLOT_W = $clog2(NS)
) (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 resetn,
  // watched inputs
  input wire logic [NR-1:0]        src_present,
  input wire logic [NS-1:0]        failsafe_en,
  input wire logic [NS-1:0]        hold_off_until_master_write,
  input wire logic [NS-1:0]        pulse_en,
  input wire logic                 checkin_valid,
  input wire logic                 coil_wr_valid,
  input wire logic [SLOT_W-1:0]    coil_wr_slot,
  input wire logic                 coil_wr_value,
  input wire logic                 manual_wr_valid,
  input wire logic                 manual_wr_sel,
  input wire logic                 manual_wr_value,
  input wire logic [RSL_REG_W-1:0] log_rd_addr,
  // watched outputs
  input wire logic [RSL_REG_W-1:0] log_rd_data_q,
  input wire logic [NS-1:0]        relay_cmd_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  a_reset_all_off: assert property (disable iff (1'b0)
    !resetn |=> relay_cmd_q == '0 && log_rd_data_q == '0) else $error("outputs not cleared by reset");
  a_log_range_zero: assert property (
    (log_rd_addr < 16'h1B58 || log_rd_addr > 16'h1B70) |=> log_rd_data_q == '0) else $error("log read outside range");
  a_coil_write_sets: assert property (
    coil_wr_valid && coil_wr_slot < NS && !manual_wr_valid && !checkin_valid && !$past(checkin_valid)
    && $stable(src_present) && !pulse_en[coil_wr_slot]
    |-> ##2 relay_cmd_q[$past(coil_wr_slot, 2)] == $past(coil_wr_value, 2)) else $error("coil write lost");
  a_manual_write_sets: assert property (
    manual_wr_valid && !checkin_valid && !$past(checkin_valid) && $stable(src_present) && !pulse_en[manual_wr_sel]
    |-> ##2 relay_cmd_q[$past(manual_wr_sel, 2)] == $past(manual_wr_value, 2)) else $error("manual write lost");
  a_quiet_holds: assert property (
    (!checkin_valid && !coil_wr_valid && !manual_wr_valid && $stable(src_present) && $stable(failsafe_en))[*4]
    |=> $stable(relay_cmd_q & ~pulse_en)) else $error("output moved without cause");
  a_rise_has_cause: assert property (
    (relay_cmd_q & ~$past(relay_cmd_q)) != '0 |-> $past(checkin_valid, 3) || $past(coil_wr_valid, 2)
    || $past(manual_wr_valid, 2) || $past(src_present, 2) != $past(src_present, 4)) else $error("unexplained rise");
  a_latch_no_rule_set: assert property (
    (relay_cmd_q & ~$past(relay_cmd_q) & hold_off_until_master_write & ~pulse_en) != '0
    |-> $past(coil_wr_valid, 2) || $past(manual_wr_valid, 2)) else $error("latched output set by rule");
  a_log_quiet_stable: assert property (
    ($stable(log_rd_addr) && !checkin_valid)[*4] |=> $stable(log_rd_data_q)) else $error("log changed idle");
endmodule // rsl_monitor

bind rsl_remote_shutdown_logic rsl_monitor #(.NR(NR), .NS(NS)) u_mon (.clock, .resetn, .src_present,
  .failsafe_en, .hold_off_until_master_write, .pulse_en, .checkin_valid, .coil_wr_valid, .coil_wr_slot,
  .coil_wr_value, .manual_wr_valid, .manual_wr_sel, .manual_wr_value, .log_rd_addr, .log_rd_data_q, .relay_cmd_q);

// *** tb/rsl_node_model.sv ***
// rsl_node_model: remote source nodes sending check-ins, and the master issuing coil writes.
// assumes: the bench calls checkin and coil_write; outputs move only at rising edges.
`timescale 1ns/1ps
module rsl_node_model
  import rsl_pkg::*;
(
  // clock
  input wire logic            clock,
  // check-in stream
  output logic                checkin_valid,
  output logic [RSL_ID_W-1:0] checkin_id,
  output logic [31:0]         checkin_value,
  // master coil write
  output logic                coil_wr_valid,
  output logic [2:0]          coil_wr_slot,
  output logic                coil_wr_value
);
  logic                ci_go = 1'b0;
  logic                cw_go = 1'b0;
  logic [RSL_ID_W-1:0] ci_id;
  logic [31:0]         ci_val;
  logic [2:0]          cw_slot;
  logic                cw_val;

  initial begin
    checkin_valid = 1'b0;
    checkin_id = '0;
    checkin_value = '0;
    coil_wr_valid = 1'b0;
    coil_wr_slot = '0;
    coil_wr_value = 1'b0;
  end

  // lines not carrying a transfer toggle so stale data is never mistaken for valid
  always @(posedge clock) begin
    checkin_valid <= ci_go;
    checkin_id <= ci_go ? ci_id : ~checkin_id;
    checkin_value <= ci_go ? ci_val : ~checkin_value;
    ci_go = 1'b0;
    coil_wr_valid <= cw_go;
    coil_wr_slot <= cw_go ? cw_slot : ~coil_wr_slot;
    coil_wr_value <= cw_go ? cw_val : ~coil_wr_value;
    cw_go = 1'b0;
  end

  task automatic checkin(input logic [RSL_ID_W-1:0] id, input logic [31:0] v);
    @(negedge clock);
    ci_id = id;
    ci_val = v;
    ci_go = 1'b1;
    @(posedge clock);
  endtask

  task automatic coil_write(input logic [2:0] s, input logic v);
    @(negedge clock);
    cw_slot = s;
    cw_val = v;
    cw_go = 1'b1;
    @(posedge clock);
  endtask
endmodule // rsl_node_model

// *** tb/rsl_remote_shutdown_logic_tb_top.sv ***
// rsl_remote_shutdown_logic_tb_top: directed tests of the shutdown rule logic.
// assumes: the node model drives check-ins and coil writes; 10 MHz clock.
`timescale 1ns/1ps
module rsl_remote_shutdown_logic_tb_top
  import rsl_pkg::*;
;
  logic clock, resetn, checkin_valid, coil_wr_valid, coil_wr_value;
  logic manual_wr_valid, manual_wr_sel, manual_wr_value;
  logic [7:0] cfg_rule_en, src_present, checkin_id;
  logic [7:0][7:0] cfg_src_id, cfg_dest_id;
  logic [7:0][1:0] cfg_cmp_op;
  logic [7:0][31:0] cfg_run_thr, cfg_stop_thr;
  logic [7:0][3:0] consecutive_trip_count, cfg_dest_chan;
  logic [5:0][7:0] slot_id;
  logic [5:0][3:0] slot_chan;
  logic [5:0] failsafe_en, hold_off_until_master_write, pulse_en, pulse_on_run, relay_cmd_q;
  logic [5:0][15:0] pulse_cycles;
  logic [31:0] checkin_value;
  logic [2:0] coil_wr_slot;
  logic [15:0] log_rd_addr, log_rd_data_q;
  logic [31:0] tv [5] = '{32'h2EE0, 32'h2EE0, 32'h34BC, 32'h2EE0, 32'h2EE0};
  logic [15:0] la [6] = '{16'h1B59, 16'h1B5A, 16'h1B5C, 16'h1B5E, 16'h1B61, 16'h1B71};
  logic [15:0] le [6] = '{16'h8003, 16'h0004, 16'h0014, 16'h0003, 16'h0001, 16'h0000};
  int errors = 0;
  int comparisons = 0;

  rsl_remote_shutdown_logic #(.NR(8), .NS(6)) u_dut (.clock, .resetn, .cfg_rule_en, .cfg_src_id, .cfg_cmp_op,
    .cfg_run_thr, .cfg_stop_thr, .consecutive_trip_count, .cfg_dest_id, .cfg_dest_chan, .src_present, .slot_id,
    .slot_chan, .failsafe_en, .hold_off_until_master_write, .pulse_en, .pulse_on_run, .pulse_cycles,
    .checkin_valid, .checkin_id, .checkin_value, .coil_wr_valid, .coil_wr_slot, .coil_wr_value, .manual_wr_valid,
    .manual_wr_sel, .manual_wr_value, .log_rd_addr, .log_rd_data_q, .relay_cmd_q);
  rsl_node_model u_node (.clock, .checkin_valid, .checkin_id, .checkin_value, .coil_wr_valid, .coil_wr_slot,
    .coil_wr_value);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge clock);
    log_rd_addr <= a;
    wt(1);
  endtask

  task automatic finish_test;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clock);
    errors++;
    finish_test;
  end

  initial begin
    resetn = 1'b0;
    {manual_wr_valid, manual_wr_sel, manual_wr_value, log_rd_addr} = '0;
    cfg_rule_en = 8'h3F;
    src_present = 8'hFF;
    cfg_src_id = 64'h0000060504030201;
    // rule 5 uses the less-than compare, rule 1 equal-to, the rest greater-than
    cfg_cmp_op = 16'h0408;
    cfg_run_thr = '0;
    cfg_stop_thr = '0;
    for (int i = 2; i < 5; i++) begin
      cfg_run_thr[i] = 32'h000A;
      cfg_stop_thr[i] = 32'h0005;
    end
    cfg_run_thr[0] = 32'h36B0;
    cfg_stop_thr[0] = 32'h32C8;
    cfg_run_thr[1] = 32'h0001;
    cfg_run_thr[5] = 32'h0005;
    cfg_stop_thr[5] = 32'h000A;
    consecutive_trip_count = {8{4'h1}};
    cfg_dest_id = {16'h0000, 8'h09, 8'h07, 8'h06, RSL_OWN_ADDR_DEF, 16'h0505};
    cfg_dest_chan = {8{4'h1}};
    slot_id = 48'h090706050000;
    slot_chan = {6{4'h1}};
    {failsafe_en, hold_off_until_master_write, pulse_en, pulse_on_run} = {6'h00, 6'h08, 6'h10, 6'h10};
    pulse_cycles = '0;
    pulse_cycles[4] = 16'h0003;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    rd(16'h1B59);
    check(log_rd_data_q, 16'h0000);
    check(relay_cmd_q, 6'h00);
    u_node.checkin(8'h01, 32'h389F);
    wt(4);
    check(relay_cmd_q[2], 1'b0);
    u_node.checkin(8'h02, 32'h0001);
    wt(4);
    check(relay_cmd_q[2], 1'b1);
    u_node.checkin(8'h01, 32'h34BC);
    wt(4);
    check(relay_cmd_q[2], 1'b1);
    u_node.checkin(8'h01, 32'h2EE0);
    wt(4);
    check(relay_cmd_q[2], 1'b0);
    u_node.checkin(8'h01, 32'h3A98);
    wt(4);
    check(relay_cmd_q[2], 1'b1);
    @(posedge clock);
    consecutive_trip_count[0] <= 4'h3;
    foreach (tv[i]) u_node.checkin(8'h01, tv[i]);
    wt(4);
    check(relay_cmd_q[2], 1'b1);
    u_node.checkin(8'h01, 32'h2EE0);
    wt(4);
    check(relay_cmd_q[2], 1'b0);
    u_node.checkin(8'h01, 32'h3A98);
    u_node.checkin(8'h02, 32'h0000);
    wt(4);
    check(relay_cmd_q[2], 1'b0);
    @(posedge clock);
    src_present[1] <= 1'b0;
    wt(4);
    check(relay_cmd_q[2], 1'b1);
    @(posedge clock);
    failsafe_en[2] <= 1'b1;
    wt(4);
    check(relay_cmd_q[2], 1'b0);
    @(posedge clock);
    src_present[1] <= 1'b1;
    wt(4);
    @(posedge clock);
    failsafe_en[2] <= 1'b0;
    u_node.checkin(8'h03, 32'h0014);
    wt(4);
    check(relay_cmd_q[0], 1'b1);
    @(posedge clock);
    {manual_wr_valid, manual_wr_sel, manual_wr_value} <= 3'b100;
    @(posedge clock);
    manual_wr_valid <= 1'b0;
    wt(1);
    check(relay_cmd_q[0], 1'b0);
    u_node.coil_write(3'h1, 1'b1);
    wt(3);
    check(relay_cmd_q[1], 1'b1);
    u_node.coil_write(3'h7, 1'b1);
    wt(3);
    check(relay_cmd_q, 6'h02);
    u_node.checkin(8'h04, 32'h0014);
    wt(4);
    check(relay_cmd_q[3], 1'b0);
    u_node.coil_write(3'h3, 1'b1);
    wt(3);
    check(relay_cmd_q[3], 1'b1);
    u_node.checkin(8'h04, 32'h0001);
    wt(4);
    check(relay_cmd_q[3], 1'b0);
    u_node.checkin(8'h04, 32'h0014);
    wt(4);
    check(relay_cmd_q[3], 1'b0);
    for (int i = 0; i < 6; i++) begin
      rd(la[i]);
      check(log_rd_data_q, le[i]);
    end
    u_node.checkin(8'h05, 32'h0014);
    wt(4);
    check(relay_cmd_q[4], 1'b1);
    wt(1);
    check(relay_cmd_q[4], 1'b1);
    wt(1);
    check(relay_cmd_q[4], 1'b0);
    // pulse on the shutdown edge instead
    @(posedge clock);
    pulse_on_run[4] <= 1'b0;
    u_node.checkin(8'h05, 32'h0001);
    wt(5);
    check(relay_cmd_q[4], 1'b1);
    wt(1);
    check(relay_cmd_q[4], 1'b0);
    // less-than rule: run below 5, hold between, stop above 10
    u_node.checkin(8'h06, 32'h0003);
    wt(4);
    check(relay_cmd_q[5], 1'b1);
    u_node.checkin(8'h06, 32'h0007);
    wt(4);
    check(relay_cmd_q[5], 1'b1);
    u_node.checkin(8'h06, 32'h000C);
    wt(4);
    check(relay_cmd_q[5], 1'b0);
    // manual command on the second local output
    @(posedge clock);
    {manual_wr_valid, manual_wr_sel, manual_wr_value} <= 3'b110;
    @(posedge clock);
    manual_wr_valid <= 1'b0;
    wt(1);
    check(relay_cmd_q[1], 1'b0);
    @(posedge clock);
    resetn <= 1'b0;
    @(posedge clock);
    resetn <= 1'b1;
    rd(16'h1B59);
    check(log_rd_data_q, 16'h0000);
    check(relay_cmd_q, 6'h00);
    finish_test;
  end
endmodule // rsl_remote_shutdown_logic_tb_top
